// [inc/crf_pkg.sv]
// package for the core register file: offsets, flag positions, reset values
// assumes an APB slave with 32-bit data and word-aligned registers
//
// Functional notes
// - thirteen registers; data, address and frame base exist in two banks
// - data registers are 16 bits; first two also split into byte halves
// - data 2:0 and 3:1 pair into 32-bit values, higher index upper
// - two 16-bit address registers for indirect, relative and general use
// - address registers pair into 32 bits, address 1 upper
// - frame base is 16 bits, base for frame-relative addressing
// - vector table base is 20 bits
// - program counter is 20 bits, address of next instruction
// - separate user and interrupt stack pointers, chosen by stack select flag
// - static base is 16 bits, base for static-relative addressing
// - status flag word is 11 bits wide
// - carry flag keeps carry, borrow or shifted-out bit from the alu
// - zero flag set when arithmetic result is zero, else cleared
// - sign flag set when arithmetic result is negative, else cleared
// - bank flag zero selects bank 0, one selects bank 1
// - overflow flag set on overflow, else cleared
// - interrupt enable gates maskable interrupts; cleared on acceptance
// - stack select cleared on hardware interrupt or soft interrupt 0..31
// - three-bit priority level; request admitted only if strictly above it
// - reserved flag bits written zero; they read as zero here
`default_nettype none
package crf_pkg;
    localparam int CRF_NREG = 16;
    localparam logic [11:0] CRF_OFS_DATA0 = 12'h000;
    localparam logic [11:0] CRF_OFS_VTB = 12'h040;
    localparam logic [11:0] CRF_OFS_PC = 12'h044;
    localparam logic [11:0] CRF_OFS_USP = 12'h048;
    localparam logic [11:0] CRF_OFS_ISP = 12'h04C;
    localparam logic [11:0] CRF_OFS_SB = 12'h050;
    localparam logic [11:0] CRF_OFS_FLG = 12'h054;
    localparam logic [11:0] CRF_OFS_PAIR_LO = 12'h058;
    localparam logic [11:0] CRF_OFS_PAIR_HI = 12'h05C;
    localparam logic [11:0] CRF_OFS_APAIR = 12'h060;
    localparam logic [11:0] CRF_OFS_INTCTL = 12'h064;
    localparam int CRF_F_C = 0;
    localparam int CRF_F_D = 1;
    localparam int CRF_F_Z = 2;
    localparam int CRF_F_S = 3;
    localparam int CRF_F_B = 4;
    localparam int CRF_F_O = 5;
    localparam int CRF_F_I = 6;
    localparam int CRF_F_U = 7;
    localparam int CRF_F_IPL = 8;
    localparam logic [10:0] CRF_FLG_MASK = 11'h7FF;
    localparam logic [10:0] CRF_FLG_RST = 11'h000;
    localparam logic [15:0] CRF_R16_RST = 16'h0000;
    localparam logic [19:0] CRF_R20_RST = 20'h00000;
    localparam logic [5:0] CRF_SWI_LAST_U = 6'h1F;

    // core-side update from the alu / decoder
    typedef struct packed {
        logic wr_en;
        logic [2:0] sel;
        logic [15:0] data;
        logic byte_en;
        logic byte_hi;
        logic flags_en;
        logic carry;
        logic ovf;
        logic [15:0] result;
        logic pc_en;
        logic [19:0] pc;
    } crf_core_t;

    typedef struct packed {
        logic hw_accept;
        logic swi_exec;
        logic [5:0] swi_num;
        logic req_valid;
        logic req_maskable;
        logic [2:0] req_prio;
    } crf_irq_t;

    typedef enum logic [1:0] {CRF_ST_IDLE, CRF_ST_ACCESS} crf_state_t;
endpackage
`default_nettype wire

// [verification/crf_core_model.sv]
// partner model: decoder, alu and interrupt acceptance side of the register file
// assumes the bench calls its tasks one at a time; each request lasts one cycle
`default_nettype none
module crf_core_model
    import crf_pkg::*;
(
    input wire logic pclk,
    output var crf_pkg::crf_core_t core_in,
    output var crf_pkg::crf_irq_t irq_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // idle levels and one-cycle requests
    // ----------------------------------------
    initial begin
        core_in = '0;
        irq_in = '0;
    end

    // the debug flag lives only in the flag word; this side never sets it
    task automatic drive_core(input crf_core_t v);
        @(posedge pclk);
        core_in <= v;
        @(posedge pclk);
        core_in <= '0;
    endtask

    task automatic drive_irq(input crf_irq_t v);
        @(posedge pclk);
        irq_in <= v;
        @(posedge pclk);
        irq_in <= '0;
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the core register file over APB plus core-side stimulus
// assumes crf_pkg offsets and flag positions, and the partner model beside the dut
`default_nettype none
module testbench
    import crf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // signals, dut and partner
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata, address_pair;
    logic pready, pslverr, irq_admit;
    logic [15:0] stack_ptr, frame_base, static_base;
    logic [19:0] vector_table_base, program_counter;
    logic [10:0] status_flag_word;
    crf_core_t core_in;
    crf_irq_t irq_in;
    int miscompares = 0;
    int tests_run = 0;
    logic last_err;

    always #2.5 pclk = ~pclk;

    crf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_in(core_in), .irq_in(irq_in),
        .irq_admit(irq_admit), .stack_ptr(stack_ptr), .frame_base(frame_base),
        .static_base(static_base), .vector_table_base(vector_table_base),
        .program_counter(program_counter), .address_pair(address_pair),
        .status_flag_word(status_flag_word));

    crf_core_model m (.pclk(pclk), .core_in(core_in), .irq_in(irq_in));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask

    // request held until pready is sampled high; data and error taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] r;
        apb(1'b1, a, d, s, r);
        chk($sformatf("wr_err %h", a), 32'h0, {31'h0, last_err});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, 4'h0, r);
        chk($sformatf("rd %h", a), exp, r);
        chk($sformatf("rd_err %h", a), 32'h0, {31'h0, last_err});
    endtask

    task automatic bad(input logic w, input logic [11:0] a);
        logic [31:0] r;
        apb(w, a, 32'hFFFFFFFF, 4'hF, r);
        chk($sformatf("refuse %h", a), 32'h1, {31'h0, last_err});
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic req(input logic [2:0] p, input logic mk, input logic exp);
        m.drive_irq('{req_valid: 1'b1, req_maskable: mk, req_prio: p, default: '0});
        #1;
        chk($sformatf("irq_admit p%0d m%0d", p, mk), {31'h0, exp}, {31'h0, irq_admit});
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(CRF_OFS_FLG, 32'h0);
        wr(CRF_OFS_VTB, 32'hFFFFFFFF);
        rd(CRF_OFS_VTB, 32'h000FFFFF);
        wr(CRF_OFS_SB, 32'h1234ABCD);
        rd(CRF_OFS_SB, 32'h0000ABCD);
        for (int i = 0; i < 7; i++) begin
            wr(12'(i * 4), {16'hFFFF, 16'h1000 + 16'(i)});
            wr(12'(32 + i * 4), {16'hFFFF, 16'h2000 + 16'(i)});
        end
        for (int i = 0; i < 7; i++) begin
            rd(12'(i * 4), 32'h1000 + 32'(i));
            rd(12'(32 + i * 4), 32'h2000 + 32'(i));
        end
        rd(CRF_OFS_PAIR_LO, 32'h10021000);
        rd(CRF_OFS_PAIR_HI, 32'h10031001);
        rd(CRF_OFS_APAIR, 32'h10051004);
        settle();
        chk("address_pair", 32'h10051004, address_pair);
        chk("frame_base", 32'h1006, {16'h0, frame_base});
        chk("static_base", 32'hABCD, {16'h0, static_base});
        chk("vector_table_base", 32'hFFFFF, {12'h0, vector_table_base});
        bad(1'b1, 12'h01C);
        bad(1'b1, CRF_OFS_PC);
        bad(1'b1, CRF_OFS_PAIR_LO);
        bad(1'b0, 12'h080);
        wr(12'h004, 32'h0000BEEF, 4'h1);
        rd(12'h004, 32'h000010EF);
        wr(CRF_OFS_FLG, 32'h00000010);
        rd(CRF_OFS_PAIR_LO, 32'h20022000);
        m.drive_core('{wr_en: 1'b1, sel: 3'h4, data: 16'h5A5A, default: '0});
        m.drive_core('{wr_en: 1'b1, byte_en: 1'b1, byte_hi: 1'b1, sel: 3'h0, data: 16'h0077,
            default: '0});
        m.drive_core('{wr_en: 1'b1, byte_en: 1'b1, sel: 3'h1, data: 16'h0033, default: '0});
        settle();
        chk("frame_base bank1", 32'h2006, {16'h0, frame_base});
        rd(12'h030, 32'h00005A5A);
        rd(12'h010, 32'h00001004);
        rd(12'h020, 32'h00007700);
        rd(12'h024, 32'h00002033);
        wr(CRF_OFS_FLG, 32'h0);
        wr(CRF_OFS_USP, 32'h00001111);
        wr(CRF_OFS_ISP, 32'h00002222);
        settle();
        chk("stack_ptr isp", 32'h2222, {16'h0, stack_ptr});
        wr(CRF_OFS_FLG, 32'h00000080);
        settle();
        chk("stack_ptr usp", 32'h1111, {16'h0, stack_ptr});
        m.drive_core('{flags_en: 1'b1, carry: 1'b1, result: 16'h0000, default: '0});
        #1;
        chk("flags zero", 32'h085, {21'h0, status_flag_word});
        m.drive_core('{flags_en: 1'b1, ovf: 1'b1, result: 16'h8000, default: '0});
        #1;
        chk("flags neg", 32'h0A8, {21'h0, status_flag_word});
        wr(CRF_OFS_FLG, 32'h000003C0);
        req(3'd3, 1'b1, 1'b0);
        req(3'd4, 1'b1, 1'b1);
        req(3'd7, 1'b1, 1'b1);
        m.drive_irq('{hw_accept: 1'b1, default: '0});
        #1;
        chk("flags hw accept", 32'h300, {21'h0, status_flag_word});
        req(3'd5, 1'b1, 1'b0);
        req(3'd5, 1'b0, 1'b1);
        req(3'd3, 1'b0, 1'b0);
        wr(CRF_OFS_FLG, 32'h000003C0);
        m.drive_irq('{swi_exec: 1'b1, swi_num: 6'h1F, default: '0});
        #1;
        chk("flags swi 31", 32'h300, {21'h0, status_flag_word});
        wr(CRF_OFS_FLG, 32'h000003C0);
        m.drive_irq('{swi_exec: 1'b1, swi_num: 6'h20, default: '0});
        #1;
        chk("flags swi 32", 32'h380, {21'h0, status_flag_word});
        wr(CRF_OFS_FLG, 32'h000007FD);
        rd(CRF_OFS_FLG, 32'h000007FD);
        m.drive_core('{pc_en: 1'b1, pc: 20'hABCDE, default: '0});
        #1;
        chk("program_counter", 32'hABCDE, {12'h0, program_counter});
        rd(CRF_OFS_PC, 32'h000ABCDE);
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verilog/crf_bank.sv]
// one bank of data, address and frame base registers
// assumes writes arrive already decoded and one per cycle
`default_nettype none
module crf_bank
    import crf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [2:0] idx,
    input wire logic [15:0] wdata,
    input wire logic [1:0] bmask,
    output logic [6:0][15:0] regs
);
    logic [6:0][15:0] regs_q;
    logic [6:0][15:0] regs_d;

    // entries 0..3 data, 4..5 address, 6 frame base
    always_comb begin
        regs_d = regs_q;
        if (we && idx < 3'd7) begin
            if (bmask[0]) regs_d[idx][7:0] = wdata[7:0];
            if (bmask[1]) regs_d[idx][15:8] = wdata[15:8];
        end
    end

    generate
        for (genvar g = 0; g < 7; g++) begin : g_ent
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) regs_q[g] <= CRF_R16_RST;
                else regs_q[g] <= regs_d[g];
            end
        end
    endgenerate

    assign regs = regs_q;
endmodule
`default_nettype wire

// [verilog/crf_top.sv]
// core register file: two banks, pc, vector base, stack pointers, flag word
// assumes one clock, APB access from debug/software, core updates on the same clock
`default_nettype none
module crf_top
    import crf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire crf_pkg::crf_core_t core_in,
    input wire crf_pkg::crf_irq_t irq_in,
    output logic irq_admit,
    output logic [15:0] stack_ptr,
    output logic [15:0] frame_base,
    output logic [15:0] static_base,
    output logic [19:0] vector_table_base,
    output logic [19:0] program_counter,
    output logic [31:0] address_pair,
    output logic [10:0] status_flag_word
);
    import crf_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [1:0][6:0][15:0] bank_regs;
    logic [19:0] vtb_q, vtb_d, pc_q, pc_d;
    logic [15:0] usp_q, usp_d, isp_q, isp_d, sb_q, sb_d;
    logic [10:0] flg_q, flg_d;
    logic irq_admit_q, irq_admit_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    crf_state_t st_q, st_d;

    logic bsel;
    logic apb_wr, apb_rd, hit;
    logic [11:0] word_ofs;
    logic [1:0] bank_we;
    logic [2:0] bank_idx;
    logic [15:0] bank_wdata;
    logic [1:0] bank_bmask;
    logic [6:0][15:0] cur;

    assign bsel = flg_q[CRF_F_B];
    assign cur = bank_regs[bsel];
    assign word_ofs = {paddr[11:2], 2'b00};

    // ------------------------------------------------------------
    // apb slave: one wait state, answer in the second access cycle
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        pready_d = 1'b0;
        case (st_q)
            CRF_ST_IDLE: begin
                if (psel && !penable) st_d = CRF_ST_ACCESS;
            end
            CRF_ST_ACCESS: begin
                if (psel && penable && !pready_q) pready_d = 1'b1;
                if (pready_q) st_d = CRF_ST_IDLE;
            end
            default: st_d = CRF_ST_IDLE;
        endcase
    end

    // a write lands at the edge where the master samples pready high, not one edge early
    assign apb_wr = psel && penable && pwrite && pready_q && hit;
    assign apb_rd = psel && penable && !pwrite && pready_d;

    always_comb begin
        hit = 1'b1;
        // entry 7 of each bank has no register behind it, so it is refused
        if (word_ofs < CRF_OFS_VTB) hit = (paddr[4:2] != 3'd7);
        else if (word_ofs == CRF_OFS_VTB) hit = 1'b1;
        else if (word_ofs == CRF_OFS_PC) hit = !pwrite;
        else if (word_ofs == CRF_OFS_USP) hit = 1'b1;
        else if (word_ofs == CRF_OFS_ISP) hit = 1'b1;
        else if (word_ofs == CRF_OFS_SB) hit = 1'b1;
        else if (word_ofs == CRF_OFS_FLG) hit = 1'b1;
        else if (word_ofs == CRF_OFS_PAIR_LO) hit = !pwrite;
        else if (word_ofs == CRF_OFS_PAIR_HI) hit = !pwrite;
        else if (word_ofs == CRF_OFS_APAIR) hit = !pwrite;
        else hit = 1'b0;
    end

    // banked area: word index = bank*8 + entry, entries 7 and 15 unmapped
    always_comb begin
        bank_we = 2'b00;
        bank_idx = core_in.sel;
        bank_wdata = core_in.data;
        bank_bmask = 2'b11;
        if (apb_wr && word_ofs < CRF_OFS_VTB) begin
            bank_we[paddr[5]] = 1'b1;
            bank_idx = paddr[4:2];
            bank_wdata = pwdata[15:0];
            bank_bmask = pstrb[1:0];
        end else if (core_in.wr_en) begin
            bank_we[bsel] = 1'b1;
            // byte access only for the first two data registers
            if (core_in.byte_en && core_in.sel < 3'd2) begin
                bank_bmask = core_in.byte_hi ? 2'b10 : 2'b01;
                bank_wdata = {core_in.data[7:0], core_in.data[7:0]};
            end
        end
    end

    generate
        for (genvar b = 0; b < 2; b++) begin : g_bank
            crf_bank u_bank (
                .pclk(pclk),
                .presetn(presetn),
                .we(bank_we[b]),
                .idx(bank_idx),
                .wdata(bank_wdata),
                .bmask(bank_bmask),
                .regs(bank_regs[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // unbanked registers and flag word
    // ------------------------------------------------------------
    always_comb begin
        vtb_d = vtb_q;
        pc_d = pc_q;
        usp_d = usp_q;
        isp_d = isp_q;
        sb_d = sb_q;
        flg_d = flg_q;
        irq_admit_d = 1'b0;
        if (core_in.pc_en) pc_d = core_in.pc;
        if (apb_wr) begin
            if (word_ofs == CRF_OFS_VTB) vtb_d = pwdata[19:0];
            else if (word_ofs == CRF_OFS_USP) usp_d = pwdata[15:0];
            else if (word_ofs == CRF_OFS_ISP) isp_d = pwdata[15:0];
            else if (word_ofs == CRF_OFS_SB) sb_d = pwdata[15:0];
            else if (word_ofs == CRF_OFS_FLG) flg_d = pwdata[10:0] & CRF_FLG_MASK;
        end
        if (core_in.flags_en) begin
            flg_d[CRF_F_C] = core_in.carry;
            flg_d[CRF_F_Z] = (core_in.result == 16'h0000);
            flg_d[CRF_F_S] = core_in.result[15];
            flg_d[CRF_F_O] = core_in.ovf;
        end
        // admission: maskable needs enable; all need priority above level
        if (irq_in.req_valid && (irq_in.req_prio > flg_q[CRF_F_IPL +: 3])
            && (!irq_in.req_maskable || flg_q[CRF_F_I])) begin
            irq_admit_d = 1'b1;
        end
        // acceptance wins over a same-cycle software write
        if (irq_in.hw_accept) begin
            flg_d[CRF_F_I] = 1'b0;
            flg_d[CRF_F_U] = 1'b0;
        end
        if (irq_in.swi_exec) begin
            if (irq_in.swi_num <= CRF_SWI_LAST_U) flg_d[CRF_F_U] = 1'b0;
            flg_d[CRF_F_I] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vtb_q <= CRF_R20_RST;
            pc_q <= CRF_R20_RST;
            usp_q <= CRF_R16_RST;
            isp_q <= CRF_R16_RST;
            sb_q <= CRF_R16_RST;
            flg_q <= CRF_FLG_RST;
            irq_admit_q <= 1'b0;
        end else begin
            vtb_q <= vtb_d;
            pc_q <= pc_d;
            usp_q <= usp_d;
            isp_q <= isp_d;
            sb_q <= sb_d;
            flg_q <= flg_d;
            irq_admit_q <= irq_admit_d;
        end
    end

    // ------------------------------------------------------------
    // read data and core-facing views
    // ------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            pslverr_d = !hit;
            if (apb_rd) begin
                if (word_ofs < CRF_OFS_VTB) begin
                    if (paddr[4:2] != 3'd7) prdata_d = {16'h0000, bank_regs[paddr[5]][paddr[4:2]]};
                end else if (word_ofs == CRF_OFS_VTB) prdata_d = {12'h000, vtb_q};
                else if (word_ofs == CRF_OFS_PC) prdata_d = {12'h000, pc_q};
                else if (word_ofs == CRF_OFS_USP) prdata_d = {16'h0000, usp_q};
                else if (word_ofs == CRF_OFS_ISP) prdata_d = {16'h0000, isp_q};
                else if (word_ofs == CRF_OFS_SB) prdata_d = {16'h0000, sb_q};
                else if (word_ofs == CRF_OFS_FLG) prdata_d = {21'h000000, flg_q};
                else if (word_ofs == CRF_OFS_PAIR_LO) prdata_d = {cur[2], cur[0]};
                else if (word_ofs == CRF_OFS_PAIR_HI) prdata_d = {cur[3], cur[1]};
                else if (word_ofs == CRF_OFS_APAIR) prdata_d = {cur[5], cur[4]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= CRF_ST_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // core-facing outputs come from flops; views lag one cycle behind storage
    logic [15:0] sp_q, fb_q;
    logic [31:0] ap_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= CRF_R16_RST;
            fb_q <= CRF_R16_RST;
            ap_q <= 32'h0000_0000;
        end else begin
            sp_q <= flg_q[CRF_F_U] ? usp_q : isp_q;
            fb_q <= cur[6];
            ap_q <= {cur[5], cur[4]};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_admit = irq_admit_q;
    assign stack_ptr = sp_q;
    assign frame_base = fb_q;
    assign static_base = sb_q;
    assign vector_table_base = vtb_q;
    assign program_counter = pc_q;
    assign address_pair = ap_q;
    assign status_flag_word = flg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        core_in.flags_en |=> flg_q[CRF_F_Z] == ($past(core_in.result) == 16'h0000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_sign;
        @(posedge pclk) disable iff (!presetn)
        core_in.flags_en |=> flg_q[CRF_F_S] == $past(core_in.result[15]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    property p_carry;
        @(posedge pclk) disable iff (!presetn)
        core_in.flags_en |=> flg_q[CRF_F_C] == $past(core_in.carry);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    property p_ovf;
        @(posedge pclk) disable iff (!presetn)
        core_in.flags_en |=> flg_q[CRF_F_O] == $past(core_in.ovf);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
    property p_accept;
        @(posedge pclk) disable iff (!presetn)
        irq_in.hw_accept |=> !flg_q[CRF_F_I] && !flg_q[CRF_F_U];
    endproperty
    a_accept: assert property (p_accept) else $error("accept did not clear flags");
    property p_swi;
        @(posedge pclk) disable iff (!presetn)
        irq_in.swi_exec && irq_in.swi_num <= CRF_SWI_LAST_U |=> !flg_q[CRF_F_U];
    endproperty
    a_swi: assert property (p_swi) else $error("soft interrupt kept stack select");
    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        irq_admit |-> $past(irq_in.req_valid)
            && $past(irq_in.req_prio) > $past(flg_q[CRF_F_IPL +: 3]);
    endproperty
    a_prio: assert property (p_prio) else $error("admitted at low priority");
    property p_sp;
        @(posedge pclk) disable iff (!presetn)
        ##1 stack_ptr == ($past(flg_q[CRF_F_U]) ? $past(usp_q) : $past(isp_q));
    endproperty
    a_sp: assert property (p_sp) else $error("wrong stack pointer");
    property p_pc;
        @(posedge pclk) disable iff (!presetn)
        core_in.pc_en |=> program_counter == $past(core_in.pc);
    endproperty
    a_pc: assert property (p_pc) else $error("pc not loaded");
    property p_mask;
        @(posedge pclk) disable iff (!presetn)
        irq_admit |-> !$past(irq_in.req_maskable) || $past(flg_q[CRF_F_I]);
    endproperty
    a_mask: assert property (p_mask) else $error("masked request admitted");
    property p_pc_hold;
        @(posedge pclk) disable iff (!presetn)
        !core_in.pc_en |=> program_counter == $past(program_counter);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved without a load");
    property p_vtb;
        @(posedge pclk) disable iff (!presetn)
        apb_wr && word_ofs == CRF_OFS_VTB |=> vector_table_base == $past(pwdata[19:0]);
    endproperty
    a_vtb: assert property (p_vtb) else $error("vector base write lost");
    // views lag storage by one cycle, so they are held against last cycle's bank
    property p_fb;
        @(posedge pclk) disable iff (!presetn)
        ##1 frame_base == $past(cur[6]);
    endproperty
    a_fb: assert property (p_fb) else $error("frame base view wrong");
    property p_apair;
        @(posedge pclk) disable iff (!presetn)
        ##1 address_pair == {$past(cur[5]), $past(cur[4])};
    endproperty
    a_apair: assert property (p_apair) else $error("address pair view wrong");
    property p_swi_high;
        @(posedge pclk) disable iff (!presetn)
        irq_in.swi_exec && irq_in.swi_num > CRF_SWI_LAST_U && !irq_in.hw_accept && !apb_wr
            |=> flg_q[CRF_F_U] == $past(flg_q[CRF_F_U]);
    endproperty
    a_swi_high: assert property (p_swi_high) else $error("stack select lost");
    property p_dbg;
        @(posedge pclk) disable iff (!presetn)
        !apb_wr |=> flg_q[CRF_F_D] == $past(flg_q[CRF_F_D]);
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug flag moved without a write");
    c_accept: cover property (@(posedge pclk) disable iff (!presetn) irq_in.hw_accept);
    c_bank1: cover property (@(posedge pclk) disable iff (!presetn) bsel && core_in.wr_en);
    c_admit: cover property (@(posedge pclk) disable iff (!presetn) irq_admit);
    c_swi_low: cover property (@(posedge pclk) disable iff (!presetn)
        irq_in.swi_exec && irq_in.swi_num <= CRF_SWI_LAST_U);
    c_refuse: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule
`default_nettype wire
